// ---- arw_consts.svh ----
// Register indices, field positions and reset values of the result and window slice
`ifndef ARW_CONSTS_SVH
`define ARW_CONSTS_SVH

// Register indices; byte address is four times the index
`define ARW_IDX_LATCH 8'h0d
`define ARW_IDX_RESULT_L 8'h10
`define ARW_IDX_RESULT_H 8'h11
`define ARW_IDX_WLT_L 8'h12
`define ARW_IDX_WLT_H 8'h13
`define ARW_IDX_WHT_L 8'h14
`define ARW_IDX_WHT_H 8'h15
`define ARW_IDX_CTRL 8'h18
`define ARW_IDX_FLAGS 8'h19
`define ARW_IDX_MASK 8'h1a

// Field positions
`define ARW_FLAG_RDY 0
`define ARW_FLAG_WIN 1
`define ARW_CTRL_MODE_LSB 0
`define ARW_CTRL_ACC_LSB 4

// Reset values
`define ARW_RST_BYTE 8'h00
`define ARW_RST_WORD 16'h0000
`define ARW_RST_FLAGS 2'h0

// Conversion limits
`define ARW_CONV_MAX 10'h3ff
`define ARW_CONV_MIN 10'h000
`define ARW_ACC_LOG2_MAX 3'h6

`endif

// ---- arw_pkg.sv ----
// Types shared by the result and window register slice
package arw_pkg;

	// Window comparator modes; other codes never match
	typedef enum logic [2:0]
	{
		ARW_WIN_NONE = 3'h0,
		ARW_WIN_BELOW = 3'h1,
		ARW_WIN_ABOVE = 3'h2,
		ARW_WIN_INSIDE = 3'h3,
		ARW_WIN_OUTSIDE = 3'h4
	} arw_wmode_e;

	// APB request from the master
	typedef struct packed
	{
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} arw_apb_req_s;

	// APB answer to the master
	typedef struct packed
	{
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} arw_apb_rsp_s;

	// One converter sample, two's complement front-end code
	typedef struct packed
	{
		logic valid;
		logic [11:0] code;
	} arw_sample_s;

	// Whole state of the slice
	typedef struct packed
	{
		logic [7:0] latch;
		logic [15:0] result;
		logic [15:0] wlt;
		logic [15:0] wht;
		logic [2:0] mode;
		logic [2:0] acc_log2;
		logic [1:0] flags;
		logic [1:0] mask;
		logic [15:0] acc;
		logic [6:0] cnt;
		arw_apb_rsp_s rsp;
		logic irq;
	} arw_state_s;

endpackage

// ---- arw_regs.sv ----
// Result, window threshold and shared wide-access latch registers behind an APB slave
//
// Added by the designer: the APB register port.
`include "arw_consts.svh"

// Register map, byte address four times the index
// Latch at 0x34, shared by all wide pairs
// Result low and high at 0x40 and 0x44, read only
// Low threshold at 0x48 and 0x4c
// High threshold at 0x50 and 0x54
// Control at 0x60: mode in 2:0, accumulate log2 in 6:4
// Flags at 0x64: ready bit 0, match bit 1, write one clears
// Mask at 0x68, same layout as the flags
// Wide pairs move low byte first, read and write alike
// Another wide access between the two halves corrupts the pair
// Software keeps pairs atomic against its own interrupt handlers

module arw_regs
(
	input wire logic pclk,
	input wire logic presetn,
	input wire arw_pkg::arw_apb_req_s apb_req,
	output arw_pkg::arw_apb_rsp_s apb_rsp,
	input wire arw_pkg::arw_sample_s sample,
	output logic irq,
	output logic result_ready,
	output logic window_match
);
	import arw_pkg::*;

	// Registered state and its next value
	arw_state_s st_ff;
	arw_state_s nxt_st;

	// Bus decode terms
	logic [7:0] idx;
	logic idx_ok;
	logic take;
	logic [7:0] wd;

	// Read data and flag update terms
	logic [31:0] rd;
	logic err;
	logic [1:0] clr;
	logic [1:0] set;

	// Sample path terms
	logic [9:0] conv;
	logic [15:0] sum;
	logic [6:0] cnt_inc;
	logic [6:0] target;

	// Saturate the front-end code to a ten bit magnitude
	function automatic logic [9:0] arw_sat10(input logic [11:0] code);
		logic [9:0] v;
		if (code[11])
		begin
			v = `ARW_CONV_MIN;
		end
		else if (code[10])
		begin
			v = `ARW_CONV_MAX;
		end
		else
		begin
			v = code[9:0];
		end
		return v;
	endfunction

	// Window test on unsigned values; reserved codes never match
	function automatic logic arw_win_hit(input logic [15:0] r, input logic [15:0] lo, input logic [15:0] hi,
		input logic [2:0] m);
		logic h;
		h = 1'b0;
		case (m)
			ARW_WIN_BELOW: h = (r < lo);
			ARW_WIN_ABOVE: h = (r > hi);
			ARW_WIN_INSIDE: h = (r > lo) && (r < hi);
			ARW_WIN_OUTSIDE: h = (r < lo) || (r > hi);
			default: h = 1'b0;
		endcase
		return h;
	endfunction

	// Byte register onto the read bus, upper lanes zero
	function automatic logic [31:0] arw_byte_rd(input logic [7:0] b);
		return {24'h000000, b};
	endfunction

	// Clamp the accumulate setting to the largest allowed batch
	function automatic logic [2:0] arw_cap_log2(input logic [2:0] f);
		logic [2:0] c;
		c = f;
		if (f > `ARW_ACC_LOG2_MAX)
		begin
			c = `ARW_ACC_LOG2_MAX;
		end
		return c;
	endfunction

	// Word aligned index decode; anything outside the window is unmapped
	assign idx = apb_req.paddr[9:2];
	assign idx_ok = (apb_req.paddr[11:10] == 2'h0) && (apb_req.paddr[1:0] == 2'h0);
	assign wd = apb_req.pwdata[7:0];

	// Next state: bus access first, then the sample path, then the flags
	always_comb
	begin
		nxt_st = st_ff;
		rd = 32'h00000000;
		err = 1'b0;
		clr = 2'h0;
		set = 2'h0;
		conv = 10'h000;
		sum = 16'h0000;
		cnt_inc = 7'h00;
		target = 7'h00;
		// One wait state: act on the first access cycle, answer on the next
		take = apb_req.psel & apb_req.penable & ~st_ff.rsp.pready;

		if (take)
		begin
			if (!idx_ok)
			begin
				err = 1'b1;
			end
			else if (idx == `ARW_IDX_LATCH)
			begin
				rd = arw_byte_rd(st_ff.latch);
				if (apb_req.pwrite)
				begin
					nxt_st.latch = wd;
				end
			end
			// Result low byte; its read arms the pair and clears the flags
			else if (idx == `ARW_IDX_RESULT_L)
			begin
				// Result is read only; writes are dropped without error
				if (!apb_req.pwrite)
				begin
					rd = arw_byte_rd(st_ff.result[7:0]);
					nxt_st.latch = st_ff.result[15:8];
					clr = 2'h3;
				end
			end
			// Result high byte, the half kept by the low read
			else if (idx == `ARW_IDX_RESULT_H)
			begin
				if (!apb_req.pwrite)
				begin
					rd = arw_byte_rd(st_ff.latch);
				end
			end
			// Low threshold, low byte
			else if (idx == `ARW_IDX_WLT_L)
			begin
				if (apb_req.pwrite)
				begin
					nxt_st.latch = wd;
				end
				else
				begin
					rd = arw_byte_rd(st_ff.wlt[7:0]);
					nxt_st.latch = st_ff.wlt[15:8];
				end
			end
			// Low threshold, high byte; a write commits the pair
			else if (idx == `ARW_IDX_WLT_H)
			begin
				if (apb_req.pwrite)
				begin
					nxt_st.wlt = {wd, st_ff.latch};
				end
				else
				begin
					rd = arw_byte_rd(st_ff.latch);
				end
			end
			// High threshold, low byte
			else if (idx == `ARW_IDX_WHT_L)
			begin
				if (apb_req.pwrite)
				begin
					nxt_st.latch = wd;
				end
				else
				begin
					rd = arw_byte_rd(st_ff.wht[7:0]);
					nxt_st.latch = st_ff.wht[15:8];
				end
			end
			// High threshold, high byte; a write commits the pair
			else if (idx == `ARW_IDX_WHT_H)
			begin
				if (apb_req.pwrite)
				begin
					nxt_st.wht = {wd, st_ff.latch};
				end
				else
				begin
					rd = arw_byte_rd(st_ff.latch);
				end
			end
			// Window mode and accumulate setting
			else if (idx == `ARW_IDX_CTRL)
			begin
				if (apb_req.pwrite)
				begin
					nxt_st.mode = wd[`ARW_CTRL_MODE_LSB +: 3];
					nxt_st.acc_log2 = arw_cap_log2(wd[`ARW_CTRL_ACC_LSB +: 3]);
					// A half-built sum under the old setting would be meaningless
					nxt_st.acc = `ARW_RST_WORD;
					nxt_st.cnt = 7'h00;
				end
				else
				begin
					rd[`ARW_CTRL_MODE_LSB +: 3] = st_ff.mode;
					rd[`ARW_CTRL_ACC_LSB +: 3] = st_ff.acc_log2;
				end
			end
			// Sticky event flags
			else if (idx == `ARW_IDX_FLAGS)
			begin
				if (apb_req.pwrite)
				begin
					clr = wd[1:0];
				end
				else
				begin
					rd[1:0] = st_ff.flags;
				end
			end
			// Interrupt mask
			else if (idx == `ARW_IDX_MASK)
			begin
				if (apb_req.pwrite)
				begin
					nxt_st.mask = wd[1:0];
				end
				else
				begin
					rd[1:0] = st_ff.mask;
				end
			end
			else
			begin
				err = 1'b1;
			end
		end

		conv = arw_sat10(sample.code);
		sum = nxt_st.acc + {6'h00, conv};
		// Batch position against the selected batch size
		cnt_inc = nxt_st.cnt + 7'h01;
		target = 7'h01 << nxt_st.acc_log2;
		// Built on nxt_st, so a control write this cycle starts a fresh batch
		if (sample.valid)
		begin
			if (cnt_inc == target)
			begin
				nxt_st.result = sum;
				nxt_st.acc = `ARW_RST_WORD;
				nxt_st.cnt = 7'h00;
				set[`ARW_FLAG_RDY] = 1'b1;
				set[`ARW_FLAG_WIN] = arw_win_hit(sum, nxt_st.wlt, nxt_st.wht, nxt_st.mode);
			end
			else
			begin
				nxt_st.acc = sum;
				nxt_st.cnt = cnt_inc;
			end
		end

		// Set beats clear so a completion during a clear is not lost
		nxt_st.flags = (st_ff.flags & ~clr) | set;
		// Level interrupt from unmasked flags
		nxt_st.irq = |(nxt_st.flags & nxt_st.mask);

		// Answer registered one cycle after the access starts
		nxt_st.rsp.pready = take;
		nxt_st.rsp.pslverr = err;
		// Read data holds until the next answer
		if (take)
		begin
			nxt_st.rsp.prdata = rd;
		end
	end

	// State register; every reset value is zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state register
	assign apb_rsp = st_ff.rsp;
	assign irq = st_ff.irq;
	assign result_ready = st_ff.flags[`ARW_FLAG_RDY];
	assign window_match = st_ff.flags[`ARW_FLAG_WIN];

endmodule

// ---- arw_regs_sva.sv ----
// Port checker for the result and window register slice
module arw_regs_sva
(
	input wire logic pclk,
	input wire logic presetn,
	input wire arw_pkg::arw_apb_req_s apb_req,
	input wire arw_pkg::arw_apb_rsp_s apb_rsp,
	input wire arw_pkg::arw_sample_s sample,
	input wire logic irq,
	input wire logic result_ready,
	input wire logic window_match
);
	import arw_pkg::*;
	// One clock domain, so shared clocking and reset
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Access phase accepted by the slave
	sequence s_take;
		apb_req.psel && apb_req.penable && !apb_rsp.pready;
	endsequence
	// Result low read with no sample landing, so no completion can mask the clear
	sequence s_result_rd;
		s_take ##0 (!apb_req.pwrite && apb_req.paddr == 12'h040 && !sample.valid);
	endsequence
	a_one_wait: assert property (s_take |=> apb_rsp.pready)
		else $error("no answer after access");
	a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("ready held too long");
	a_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
		else $error("error without ready");
	a_misalign_err: assert property (s_take ##0 apb_req.paddr[1:0] != 2'h0 |=> apb_rsp.pslverr)
		else $error("misaligned access not refused");
	a_byte_wide: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_read_clears: assert property (s_result_rd |=> !result_ready && !window_match)
		else $error("result read left flags");
	a_ready_cause: assert property ($rose(result_ready) |-> $past(sample.valid))
		else $error("ready flag without sample");
	a_match_cause: assert property ($rose(window_match) |-> $past(sample.valid) && result_ready)
		else $error("match flag without completion");
endmodule

bind arw_regs arw_regs_sva i_arw_regs_sva
(
	.pclk(pclk),
	.presetn(presetn),
	.apb_req(apb_req),
	.apb_rsp(apb_rsp),
	.sample(sample),
	.irq(irq),
	.result_ready(result_ready),
	.window_match(window_match)
);

// ---- tb_top.sv ----
// Self-checking bench for the result and window register slice
`define CHK(n, x, g) \
	begin \
		comparisons++; \
		if ((g) !== (x)) \
		begin \
			num_errors++; \
			$display("ERROR %s exp %h got %h", n, x, g); \
		end \
	end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import arw_pkg::*;
	logic pclk = 0;
	logic presetn = 0;
	arw_apb_req_s req = '0;
	arw_apb_rsp_s rsp;
	arw_sample_s smp = '0;
	logic irq;
	logic rdy;
	logic win;
	int num_errors = 0;
	int comparisons = 0;
	int cyc = 0;
	int m;
	int k;
	logic [7:0] q;
	logic [7:0] d;
	logic e;
	logic [15:0] r;
	logic [11:0] codes [8] = '{12'hf00, 12'h0ff, 12'h100, 12'h150, 12'h200, 12'h201, 12'h7ff, 12'h0};

	arw_regs i_arw_regs
	(
		.pclk(pclk),
		.presetn(presetn),
		.apb_req(req),
		.apb_rsp(rsp),
		.sample(smp),
		.irq(irq),
		.result_ready(rdy),
		.window_match(win)
	);

	// 50 MHz clock
	always #10 pclk = ~pclk;

	// Expected conversion: negatives clamp, overrange saturates
	function automatic logic [15:0] conv(input logic [11:0] c);
		if (c[11])
			return 16'h0;
		if (c[10])
			return 16'h03ff;
		return {6'h0, c[9:0]};
	endfunction

	// Expected window verdict on unsigned values
	function automatic logic hit(input logic [2:0] md, input logic [15:0] v, lo, hi);
		case (md)
			3'h1: return v < lo;
			3'h2: return v > hi;
			3'h3: return v > lo && v < hi;
			3'h4: return v < lo || v > hi;
			default: return 1'b0;
		endcase
	endfunction

	// One APB transfer; a fresh edge first, so calls never collide
	// Waits for the answer however long; only the cycle ceiling ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd);
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, {24'h0, wd}};
		@(posedge pclk);
		req.penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (rsp.pready !== 1'b1);
		q = rsp.prdata[7:0];
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	// Wide pairs: low byte first
	task automatic wr16(input logic [11:0] a, input logic [15:0] v);
		apb(1'b1, a, v[7:0]);
		apb(1'b1, a + 12'h4, v[15:8]);
	endtask

	task automatic rd16(input logic [11:0] a);
		apb(1'b0, a, 8'h0);
		r[7:0] = q;
		apb(1'b0, a + 12'h4, 8'h0);
		r[15:8] = q;
	endtask

	// Latch and every wide register read zero after a reset
	task automatic chk_reset;
		int i;
		apb(1'b0, 12'h034, 8'h0);
		`CHK("latch reset", 8'h00, q)
		for (i = 0; i < 3; i++)
		begin
			rd16(12'h040 + 12'(8 * i));
			`CHK("reset", 16'h0, r)
		end
	endtask

	// Sample valid for n edges, then one edge for the result
	task automatic feed(input logic [11:0] c, input int n);
		@(posedge pclk);
		smp <= '{1'b1, c};
		repeat (n) @(posedge pclk);
		smp.valid <= 1'b0;
		@(posedge pclk);
	endtask

	// Counts and verdict
	task automatic complete_run;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Cycle ceiling against hangs
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			complete_run;
		end
	end

	// Main sequence
	initial
	begin
		void'($urandom(1628));
		codes[7] = 12'($urandom);
		d = 8'($urandom);
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		chk_reset();
		apb(1'b1, 12'h034, d);
		apb(1'b0, 12'h034, 8'h0);
		`CHK("latch", d, q)
		apb(1'b0, 12'h035, 8'h0);
		`CHK("misalign", 1'b1, e)
		apb(1'b0, 12'h03c, 8'h0);
		`CHK("unmapped", 1'b1, e)
		wr16(12'h048, 16'h0100);
		wr16(12'h050, 16'h0200);
		rd16(12'h048);
		`CHK("low thr", 16'h0100, r)
		rd16(12'h050);
		`CHK("high thr", 16'h0200, r)
		// Every mode against values around both thresholds
		for (m = 0; m < 8; m++)
			for (k = 0; k < 8; k++)
			begin
				apb(1'b1, 12'h060, 8'(m));
				feed(codes[k], 1);
				`CHK("match", hit(3'(m), conv(codes[k]), 16'h0100, 16'h0200), win)
				`CHK("ready", 1'b1, rdy)
				rd16(12'h040);
				`CHK("result", conv(codes[k]), r)
				`CHK("clear", 2'b00, {rdy, win})
			end
		apb(1'b1, 12'h068, 8'h3);
		feed(12'h0ff, 1);
		@(posedge pclk);
		`CHK("irq", 1'b1, irq)
		apb(1'b0, 12'h064, 8'h0);
		`CHK("flags", 8'h01, q)
		apb(1'b1, 12'h068, 8'h2);
		@(posedge pclk);
		`CHK("masked", 1'b0, irq)
		apb(1'b0, 12'h068, 8'h0);
		`CHK("mask", 8'h02, q)
		apb(1'b1, 12'h064, 8'h1);
		@(posedge pclk);
		`CHK("w1c", 1'b0, rdy)
		// Largest sum, compared only at the end
		apb(1'b1, 12'h060, 8'h72);
		apb(1'b0, 12'h060, 8'h0);
		`CHK("cap", 8'h62, q)
		feed(12'h7ff, 63);
		`CHK("partial", 2'b00, {rdy, win})
		feed(12'h7ff, 1);
		`CHK("final", 1'b1, win)
		rd16(12'h040);
		`CHK("sum", 16'hffc0, r)
		// Result bytes ignore writes
		apb(1'b1, 12'h040, 8'h55);
		apb(1'b1, 12'h044, 8'h55);
		rd16(12'h040);
		`CHK("read only", 16'hffc0, r)
		// Reset in mid-run clears thresholds and latch again
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk_reset();
		complete_run;
	end
endmodule
